// ---- analog_die_io_control.sv ----
// Analog die I/O control: bus transceiver control, analog mux select, aux current source
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
// Contract
// R01 - The bus transmitter is enabled only while the power-stage-on bit is set.
// R02 - The bus-current-limit flag in the system status register shows current-limit operation.
// R03 - Software should watch the current-limit flag and switch the transmitter off at once.
// R04 - A low transmit input drives the bus dominant; a high one releases it recessive.
// R05 - The transmit input defaults high so the bus stays recessive while undriven.
// R06 - The receive output mirrors the bus level.
// R07 - In stop mode the transmitter is off while the receiver stays active.
// R08 - With the bus interrupt enabled a bus falling edge interrupts, and in stop mode wakes the system.
// R09 - The analog select register holds a read/write four-bit channel field, upper bits zero, reset zero.
// R10 - Channel codes 0-3 pick half-bridge sense, 4 supply, 5 temperature, 7 aux input; others unused.
// R11 - The low-side current sense offers a selectable high or low resolution scale.
// R12 - The aux current source is on only when power-stage-on and current-source-on are both set.
// R13 - The level field chooses 10, 30, 60 or 100 percent of full current.
// R14 - The aux current source is off during stop mode.
// R15 - The bus falling-edge flag sets on each falling edge, clears on write one, and resets clear.
// R16 - The bus interrupt enable bit is read/write, gates the flag and resets clear.
// R17 - The interrupt request is flag AND enable, held as a level until cleared.
module analog_die_io_control (
    // Clock, reset, enable
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // Register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Transceiver
    input wire logic tx_data_in,
    input wire logic tx_data_driven_in,
    input wire logic bus_level_in,
    input wire logic current_limit_in,
    output logic bus_drive_low_out,
    output logic rx_data_out,
    // Power state and interrupt
    output logic stop_mode_out,
    output logic regulator_on_out,
    output logic irq_out,
    // Analog steering
    output aio_pkg::mux_route_t mux_route_out,
    output logic aux_source_on_out,
    output logic [7:0] aux_source_level_out
);
    typedef struct packed {
        logic [3:0] channel;
        logic [7:0] control;
        logic [7:0] power_output;
        logic bus_irq_enable;
        logic bus_prev;
        logic [7:0] rdata;
        aio_pkg::mux_route_t route;
        logic source_on;
        logic [7:0] source_level;
        logic regulator_on;
    } core_state_t;

    core_state_t state;
    core_state_t next_state;
    aio_pkg::bus_req_t req;
    logic tx_level;
    logic tx_enable;
    logic bus_falling;
    logic edge_clear;
    logic bus_falling_edge_flag;
    logic irq_level;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic aio_pkg::mux_route_t decode_channel(input logic [3:0] code, input logic high_res);
        aio_pkg::mux_route_t r;
        r = '0;
        r.high_res = high_res; // R11
        if (code[3:2] == 2'b00) begin
            r.half_bridge_sense[code[1:0]] = 1'b1; // R10
        end
        r.supply_prescaler = (code == aio_pkg::CH_SUPPLY_PRESCALER); // R10
        r.temperature = (code == aio_pkg::CH_TEMPERATURE); // R10
        r.aux_input = (code == aio_pkg::CH_AUX_INPUT); // R10
        return r;
    endfunction : decode_channel

    function automatic logic [7:0] level_percent(input logic [1:0] sel);
        logic [7:0] p;
        p = aio_pkg::LEVEL_10;
        unique case (sel)
            2'b00: p = aio_pkg::LEVEL_10; // R13
            2'b01: p = aio_pkg::LEVEL_30; // R13
            2'b10: p = aio_pkg::LEVEL_60; // R13
            2'b11: p = aio_pkg::LEVEL_100; // R13
        endcase
        return p;
    endfunction : level_percent

    // ----------------------------------------
    // Transceiver path
    // ----------------------------------------
    assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
    // Undriven transmit input reads as high, like the on-pin pull-up
    assign tx_level = tx_data_driven_in ? tx_data_in : 1'b1; // R05
    assign tx_enable = state.control[aio_pkg::POWER_STAGE_ON_BIT]
        & ~state.control[aio_pkg::STOP_MODE_BIT]; // R01 R07
    assign bus_drive_low_out = tx_enable & ~tx_level; // R04
    // Receiver stays live in every mode
    assign rx_data_out = bus_level_in; // R06 R07
    assign bus_falling = state.bus_prev & ~bus_level_in;
    assign edge_clear = req.wr && req.addr == aio_pkg::OFF_IRQ_FLAG && req.wdata[aio_pkg::BUS_EDGE_BIT];

    aio_edge_flag u_edge_flag (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .set_in(bus_falling), // R15
        .clear_in(edge_clear), // R15
        .flag_out(bus_falling_edge_flag)
    );

    assign irq_level = bus_falling_edge_flag & state.bus_irq_enable; // R16 R17
    assign irq_out = irq_level; // R08 R17

    // ----------------------------------------
    // Registers and steering
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_state.bus_prev = bus_level_in;
        next_state.rdata = aio_pkg::RESET_BYTE;
        if (req.wr) begin
            unique case (req.addr)
                aio_pkg::OFF_IRQ_MASK: next_state.bus_irq_enable = req.wdata[aio_pkg::BUS_EDGE_BIT]; // R16
                aio_pkg::OFF_ANALOG_SELECT: next_state.channel = req.wdata[3:0]; // R09
                aio_pkg::OFF_POWER_OUTPUT: next_state.power_output = req.wdata;
                aio_pkg::OFF_SYSTEM_CONTROL: next_state.control = req.wdata;
                default: ;
            endcase
        end
        // Wake-up: an enabled bus edge in stop mode leaves stop and restarts the regulator
        if (irq_level && state.control[aio_pkg::STOP_MODE_BIT]) begin
            next_state.control[aio_pkg::STOP_MODE_BIT] = 1'b0; // R08
        end
        next_state.regulator_on = ~next_state.control[aio_pkg::STOP_MODE_BIT]; // R08
        if (req.rd) begin
            unique case (req.addr)
                aio_pkg::OFF_IRQ_MASK: next_state.rdata[aio_pkg::BUS_EDGE_BIT] = state.bus_irq_enable; // R16
                aio_pkg::OFF_IRQ_FLAG: next_state.rdata[aio_pkg::BUS_EDGE_BIT] = bus_falling_edge_flag; // R15
                aio_pkg::OFF_ANALOG_SELECT: next_state.rdata = {4'h0, state.channel}; // R09
                aio_pkg::OFF_POWER_OUTPUT: next_state.rdata = state.power_output;
                aio_pkg::OFF_SYSTEM_STATUS: next_state.rdata[aio_pkg::CURRENT_LIMIT_BIT] = current_limit_in; // R02
                aio_pkg::OFF_SYSTEM_CONTROL: next_state.rdata = state.control;
                default: ;
            endcase
        end
        next_state.route = decode_channel(next_state.channel, next_state.control[aio_pkg::HIGH_RES_BIT]);
        next_state.source_on = next_state.control[aio_pkg::POWER_STAGE_ON_BIT]
            & next_state.power_output[aio_pkg::CURRENT_SOURCE_ON_BIT]
            & ~next_state.control[aio_pkg::STOP_MODE_BIT]; // R12 R14
        next_state.source_level = next_state.source_on
            ? level_percent(next_state.power_output[aio_pkg::LEVEL_SELECT_LSB +: 2]) : 8'h00; // R13 R14
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state <= '0;
            state.bus_prev <= 1'b1;
            state.regulator_on <= 1'b1;
        end else if (clk_en_in) begin
            state <= next_state;
        end
    end

    assign reg_rdata_out = state.rdata;
    assign stop_mode_out = state.control[aio_pkg::STOP_MODE_BIT];
    assign regulator_on_out = state.regulator_on;
    assign mux_route_out = state.route;
    assign aux_source_on_out = state.source_on;
    assign aux_source_level_out = state.source_level;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_tx_gate;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        bus_drive_low_out |-> state.control[aio_pkg::POWER_STAGE_ON_BIT] && !stop_mode_out;
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("transmitter driven while disabled"); // R01

    property p_tx_follow;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        tx_enable |-> bus_drive_low_out == ~tx_level;
    endproperty
    a_tx_follow: assert property (p_tx_follow) else $error("bus drive does not follow transmit input"); // R04

    property p_rx_mirror;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        rx_data_out == bus_level_in;
    endproperty
    a_rx_mirror: assert property (p_rx_mirror) else $error("receive output differs from bus"); // R06

    sequence s_edge_seen;
        clk_en_in && $fell(bus_level_in) && $past(clk_en_in);
    endsequence
    property p_edge_flag;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        s_edge_seen ##1 clk_en_in |-> bus_falling_edge_flag;
    endproperty
    a_edge_flag: assert property (p_edge_flag) else $error("falling edge not flagged"); // R15

    property p_irq_level;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        irq_out && !edge_clear && !(reg_wr_in && reg_addr_in == aio_pkg::OFF_IRQ_MASK) |=> irq_out;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt dropped before clear"); // R17

    property p_wake;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        irq_out && stop_mode_out && clk_en_in && !reg_wr_in |=> !stop_mode_out && regulator_on_out;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake-up on bus interrupt"); // R08

    property p_channel_rw;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        reg_wr_in && reg_addr_in == aio_pkg::OFF_ANALOG_SELECT && clk_en_in
        ##1 reg_rd_in && reg_addr_in == aio_pkg::OFF_ANALOG_SELECT && clk_en_in
        |=> reg_rdata_out == {4'h0, $past(reg_wdata_in[3:0], 2)};
    endproperty
    a_channel_rw: assert property (p_channel_rw) else $error("channel field readback wrong"); // R09

    property p_source_gate;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        aux_source_on_out |-> state.control[aio_pkg::POWER_STAGE_ON_BIT]
            && state.power_output[aio_pkg::CURRENT_SOURCE_ON_BIT] && !stop_mode_out;
    endproperty
    a_source_gate: assert property (p_source_gate) else $error("current source on while gated"); // R12 R14

    property p_route_temp;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        mux_route_out.temperature == (state.channel == aio_pkg::CH_TEMPERATURE);
    endproperty
    a_route_temp: assert property (p_route_temp) else $error("temperature route wrong"); // R10

    sequence s_clean_clear;
        reg_wr_in && reg_addr_in == aio_pkg::OFF_IRQ_FLAG && reg_wdata_in[aio_pkg::BUS_EDGE_BIT]
            && clk_en_in && !bus_falling;
    endsequence
    property p_flag_clear;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        s_clean_clear |=> !bus_falling_edge_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("edge flag not cleared by write one"); // R15

    property p_flag_hold;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        bus_falling_edge_flag && !edge_clear |=> bus_falling_edge_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("edge flag lost without a clear"); // R15

    sequence s_mask_write;
        reg_wr_in && reg_addr_in == aio_pkg::OFF_IRQ_MASK && clk_en_in;
    endsequence
    property p_mask_write;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        s_mask_write |=> state.bus_irq_enable == $past(reg_wdata_in[aio_pkg::BUS_EDGE_BIT]);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("interrupt enable not written"); // R16

    property p_stop_tx;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        stop_mode_out |-> !bus_drive_low_out;
    endproperty
    a_stop_tx: assert property (p_stop_tx) else $error("transmitter active in stop mode"); // R07

    sequence s_status_read;
        reg_rd_in && reg_addr_in == aio_pkg::OFF_SYSTEM_STATUS && clk_en_in;
    endsequence
    property p_limit_read;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        s_status_read |=> reg_rdata_out[aio_pkg::CURRENT_LIMIT_BIT] == $past(current_limit_in);
    endproperty
    a_limit_read: assert property (p_limit_read) else $error("current-limit status not reported"); // R02

    property p_level_off;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        !aux_source_on_out |-> aux_source_level_out == 8'h00;
    endproperty
    a_level_off: assert property (p_level_off) else $error("source level shown while off"); // R14

    property p_level_full;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        aux_source_on_out && state.power_output[aio_pkg::LEVEL_SELECT_LSB +: 2] == 2'b11
            |-> aux_source_level_out == aio_pkg::LEVEL_100;
    endproperty
    a_level_full: assert property (p_level_full) else $error("full source level wrong"); // R13

    sequence s_control_write;
        reg_wr_in && reg_addr_in == aio_pkg::OFF_SYSTEM_CONTROL && clk_en_in;
    endsequence
    property p_high_res;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        s_control_write |=> mux_route_out.high_res == $past(reg_wdata_in[aio_pkg::HIGH_RES_BIT]);
    endproperty
    a_high_res: assert property (p_high_res) else $error("resolution select not applied"); // R11

    // A low enable must freeze the registers and the edge flag alike
    property p_freeze;
        @(posedge core_clk_in) disable iff (sys_rst_in)
        !clk_en_in |=> $stable(state) && $stable(bus_falling_edge_flag);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
endmodule : analog_die_io_control

// ---- aio_pkg.sv ----
// Package: register map, field layouts and carrier types for the analog die I/O control
package aio_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [3:0] OFF_IRQ_MASK = 4'h4;
    localparam logic [3:0] OFF_IRQ_FLAG = 4'h5;
    localparam logic [3:0] OFF_ANALOG_SELECT = 4'h7;
    localparam logic [3:0] OFF_POWER_OUTPUT = 4'hB;
    localparam logic [3:0] OFF_SYSTEM_STATUS = 4'hC;
    localparam logic [3:0] OFF_SYSTEM_CONTROL = 4'hD;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BUS_EDGE_BIT = 5;
    localparam int CURRENT_LIMIT_BIT = 6;
    localparam int POWER_STAGE_ON_BIT = 5;
    localparam int STOP_MODE_BIT = 0;
    localparam int HIGH_RES_BIT = 1;
    localparam int CURRENT_SOURCE_ON_BIT = 3;
    localparam int LEVEL_SELECT_LSB = 4;
    localparam int CHANNEL_SELECT_WIDTH = 4;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [3:0] RESET_CHANNEL = 4'h0;
    // ----------------------------------------
    // Channel codes and source levels
    // ----------------------------------------
    localparam logic [3:0] CH_SUPPLY_PRESCALER = 4'h4;
    localparam logic [3:0] CH_TEMPERATURE = 4'h5;
    localparam logic [3:0] CH_AUX_INPUT = 4'h7;
    localparam logic [7:0] LEVEL_10 = 8'h0A;
    localparam logic [7:0] LEVEL_30 = 8'h1E;
    localparam logic [7:0] LEVEL_60 = 8'h3C;
    localparam logic [7:0] LEVEL_100 = 8'h64;

    // Register-bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    // Analog mux steering
    typedef struct packed {
        logic [3:0] half_bridge_sense;
        logic supply_prescaler;
        logic temperature;
        logic aux_input;
        logic high_res;
    } mux_route_t;
endpackage : aio_pkg

// ---- aio_edge_flag.sv ----
// Sticky event flag with write-one-to-clear, set winning over clear
`timescale 1ns/1ps
module aio_edge_flag (
    // Clock, reset, enable
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // Event and clear
    input wire logic set_in,
    input wire logic clear_in,
    // State
    output logic flag_out
);
    typedef struct packed {
        logic flag;
    } flag_state_t;

    flag_state_t state;
    flag_state_t next_state;

    always_comb begin
        next_state = state;
        // Set wins so an edge in the clearing cycle is kept
        if (set_in) begin
            next_state.flag = 1'b1;
        end else if (clear_in) begin
            next_state.flag = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state <= '0;
        end else if (clk_en_in) begin
            state <= next_state;
        end
    end

    assign flag_out = state.flag;
endmodule : aio_edge_flag

// ---- aio_bus_model.sv ----
// Stand-in for the single-wire bus and the transmitter's current sensing
`timescale 1ns/1ps
module aio_bus_model (
    // From the block
    input wire logic drive_low_in,
    // Scenario controls
    input wire logic remote_dom_in,
    input wire logic limit_req_in,
    // To the block
    output logic bus_level_out,
    output logic limit_out
);
    // Pull-up keeps the wire recessive whenever no node sinks it
    assign bus_level_out = ~(drive_low_in | remote_dom_in);
    // Limiting only shows while our own driver really sinks current
    assign limit_out = drive_low_in & limit_req_in;
endmodule : aio_bus_model

// ---- tb.sv ----
// Self-checking bench for the analog die I/O control block
`timescale 1ns/1ps
module tb;
    // ----------------------------------------
    // Stimulus, observation and bookkeeping
    // ----------------------------------------
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic tx_data_in = 1'b0;
    logic tx_data_driven_in = 1'b0;
    logic remote_dom = 1'b0;
    logic limit_req = 1'b0;
    logic [7:0] reg_rdata_out;
    logic bus_level_in, current_limit_in, bus_drive_low_out, rx_data_out;
    logic stop_mode_out, regulator_on_out, irq_out, aux_source_on_out;
    logic [7:0] aux_source_level_out;
    aio_pkg::mux_route_t mux_route_out;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    logic rd_pend = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] lvl [4] = '{aio_pkg::LEVEL_10, aio_pkg::LEVEL_30, aio_pkg::LEVEL_60, aio_pkg::LEVEL_100};

    always #10 core_clk_in = ~core_clk_in;

    analog_die_io_control dut (.core_clk_in, .sys_rst_in, .clk_en_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .tx_data_in, .tx_data_driven_in, .bus_level_in,
        .current_limit_in, .bus_drive_low_out, .rx_data_out, .stop_mode_out, .regulator_on_out,
        .irq_out, .mux_route_out, .aux_source_on_out, .aux_source_level_out);
    aio_bus_model bus (.drive_low_in(bus_drive_low_out), .remote_dom_in(remote_dom),
        .limit_req_in(limit_req), .bus_level_out(bus_level_in), .limit_out(current_limit_in));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    // Strobes stay up until the next access, idle or pins call, so accesses run back to back
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_wr_in <= w;
        reg_rd_in <= ~w;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        if (!w) exp_q.push_back(d);
        @(negedge core_clk_in);
    endtask : acc

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge core_clk_in);
            reg_wr_in <= 1'b0;
            reg_rd_in <= 1'b0;
            @(negedge core_clk_in);
        end
    endtask : idle

    // Pin order: tx level, tx driven, remote dominant, limit request
    task automatic pins(input logic [3:0] p);
        @(posedge core_clk_in);
        {tx_data_in, tx_data_driven_in, remote_dom, limit_req} <= p;
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        @(negedge core_clk_in);
    endtask : pins

    // Read data stand only in the cycle after the strobe
    always @(posedge core_clk_in) rd_pend <= reg_rd_in;
    always @(negedge core_clk_in) begin
        if (rd_pend) check(reg_rdata_out, exp_q.pop_front());
    end

    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h4fa1));
        repeat (12) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        @(negedge core_clk_in);
        check(8'({stop_mode_out, irq_out, aux_source_on_out, bus_drive_low_out}), 8'h00);
        check(8'(regulator_on_out), 8'h01);
        for (int a = 0; a < 16; a++) acc(1'b0, 4'(a), 8'h00);
        pins(4'b0100);
        check(8'(bus_drive_low_out), 8'h00);
        acc(1'b1, aio_pkg::OFF_SYSTEM_CONTROL, 8'h20);
        idle(1);
        check(8'({bus_drive_low_out, rx_data_out}), 8'h02);
        pins(4'b0000);
        check(8'({bus_drive_low_out, rx_data_out}), 8'h01);
        pins(4'b1100);
        check(8'({bus_drive_low_out, rx_data_out}), 8'h01);
        pins(4'b1110);
        check(8'(rx_data_out), 8'h00);
        pins(4'b1100);
        check(8'(irq_out), 8'h00);
        acc(1'b0, aio_pkg::OFF_IRQ_FLAG, 8'h20);
        acc(1'b1, aio_pkg::OFF_IRQ_FLAG, 8'h00);
        acc(1'b0, aio_pkg::OFF_IRQ_FLAG, 8'h20);
        acc(1'b1, aio_pkg::OFF_IRQ_MASK, 8'h20);
        acc(1'b0, aio_pkg::OFF_IRQ_MASK, 8'h20);
        check(8'(irq_out), 8'h01);
        acc(1'b1, aio_pkg::OFF_IRQ_FLAG, 8'h20);
        idle(1);
        check(8'(irq_out), 8'h00);
        acc(1'b0, aio_pkg::OFF_IRQ_FLAG, 8'h00);
        pins(4'b0101);
        acc(1'b0, aio_pkg::OFF_SYSTEM_STATUS, 8'h40);
        idle(1);
        // Limiting burns power in the driver, so software drops the stage at once
        if (reg_rdata_out[6] === 1'b1) acc(1'b1, aio_pkg::OFF_SYSTEM_CONTROL, 8'h00);
        idle(1);
        check(8'(bus_drive_low_out), 8'h00);
        acc(1'b0, aio_pkg::OFF_SYSTEM_STATUS, 8'h00);
        pins(4'b1100);
        acc(1'b1, aio_pkg::OFF_SYSTEM_CONTROL, 8'h02);
        for (int c = 0; c < 16; c++) begin
            acc(1'b1, aio_pkg::OFF_ANALOG_SELECT, {4'($urandom), 4'(c)});
            acc(1'b0, aio_pkg::OFF_ANALOG_SELECT, {4'h0, 4'(c)});
            idle(1);
            check(mux_route_out, {(c < 4) ? 4'(1 << c) : 4'h0, c == 4, c == 5, c == 7, 1'b1});
        end
        acc(1'b1, aio_pkg::OFF_SYSTEM_CONTROL, 8'h00);
        idle(2);
        check(8'(mux_route_out.high_res), 8'h00);
        @(posedge core_clk_in);
        clk_en_in <= 1'b0;
        acc(1'b1, aio_pkg::OFF_ANALOG_SELECT, 8'h03);
        @(posedge core_clk_in);
        clk_en_in <= 1'b1;
        reg_wr_in <= 1'b0;
        acc(1'b0, aio_pkg::OFF_ANALOG_SELECT, 8'h0F);
        for (int k = 0; k < 16; k++) begin
            acc(1'b1, aio_pkg::OFF_SYSTEM_CONTROL, {2'b0, k[3], 5'h00});
            acc(1'b1, aio_pkg::OFF_POWER_OUTPUT, {2'b0, 2'(k), k[2], 3'h0});
            idle(2);
            check(8'(aux_source_on_out), 8'(k[3] & k[2]));
            check(aux_source_level_out, (k[3] & k[2]) ? lvl[k[1:0]] : 8'h00);
        end
        // Clear the old edge first, or the enabled interrupt wakes the block at once
        acc(1'b1, aio_pkg::OFF_IRQ_FLAG, 8'h20);
        acc(1'b1, aio_pkg::OFF_SYSTEM_CONTROL, 8'h21);
        pins(4'b0100);
        idle(1);
        check(8'({aux_source_on_out, stop_mode_out, regulator_on_out, bus_drive_low_out, rx_data_out}), 8'h09);
        pins(4'b0110);
        idle(1);
        check(8'({irq_out, stop_mode_out}), 8'h03);
        idle(2);
        check(8'({stop_mode_out, regulator_on_out}), 8'h01);
        idle(2);
        wrap_up();
    end
endmodule : tb
